//--- hw/smsv_supervisor.sv
`timescale 1ns/1ps
// How it works
// - target on from direct input or on bit
// - duty term compares low eight duty bits
// - rising wake pin or direct input wakes device
// - idle direct input drops activity flag after timeout
// - no activity and pin low gives sleep
// - pin low or failsafe: direct inputs only
// - wake is pin or either activity flag
// - failsafe on watchdog timeout or supply loss
// - fault is or of all fault sources, overvoltage only when armed
// - mode table selects sleep normal failsafe fault
// - watchdog off bit blocks failsafe entry on watchdog timeout, not on supply loss
// - sleep is default, registers held at defaults except por and parallel
// - failsafe entry: output low, registers reset, blocked
// - watchdog starts on pin rise, checks toggle bit
// - bit15 word leaves failsafe, second word unlocks
// - back to normal: output high, state reset
// - fault enables and latchables take default values
// - fault pin live, fault bits sticky till read
// - any fault enters fault mode and turns off both channels
// - supply loss counts only after seen and armed
module smsv_supervisor #(
  parameter int unsigned IN_TO_CYC = smsv_pkg::IN_TIMEOUT_CYC,  // activity timeout
  parameter int unsigned WD_TO_CYC = smsv_pkg::WDOG_TIMEOUT_CYC  // watchdog timeout
) (
  input wire logic clk_in,  // 100 MHz oscillator
  input wire logic rst_n_in,  // async reset, active low
  input wire logic psel_in,  // apb select
  input wire logic penable_in,  // apb enable
  input wire logic pwrite_in,  // apb direction
  input wire logic [smsv_pkg::ADDR_W-1:0] paddr_in,  // apb address
  input wire logic [31:0] pwdata_in,  // apb write data
  output logic [31:0] prdata_out,  // apb read data
  output logic pready_out,  // apb ready
  output logic pslverr_out,  // apb error
  input wire logic wake_reset_pin_in,  // wake/reset pin
  input wire logic [1:0] direct_in,  // direct channel inputs
  input wire logic vdd_ok_in,  // logic supply present
  input wire logic [1:0] current_limit_fault_in,  // overcurrent per channel
  input wire logic [1:0] thermal_fault_in,  // overtemperature per channel
  input wire logic [1:0] hard_short_fault_in,  // severe short per channel
  input wire logic supply_low_fault_in,  // undervoltage
  input wire logic supply_high_fault_in,  // overvoltage
  output logic [1:0] hson_out,  // target switch state
  output logic [1:0] mode_out,  // current mode code
  output logic failsafe_out_n_out,  // fail-safe pin level
  output logic failsafe_oe_out,  // fail-safe pin drive enable
  output logic fault_flag_n_out,  // fault pin level
  output logic fault_oe_out  // fault pin drive enable
);
  import smsv_pkg::*;

  localparam int INW = $clog2(IN_TO_CYC + 1);
  localparam int WDW = $clog2(WD_TO_CYC + 1);

  // ========================================================================
  // elaboration checks
  if (IN_TO_CYC < 2 || WD_TO_CYC < 2) begin : g_bad_param
    $error("timeout counts must be at least two cycles");
  end

  // ========================================================================
  // state
  smsv_mode_t mode_reg, mode_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [DUTY_W-1:0] duty_reg [2];
  logic [7:0] pwm_cnt_reg;
  logic [1:0] din_d_reg, act_reg;
  logic [INW-1:0] act_cnt_reg [2];
  logic pin_d_reg, vdd_seen_reg, fs_reg, unlock_reg, wd_run_reg, wd_last_reg;
  logic [WDW-1:0] wd_cnt_reg;
  logic [1:0] st_sticky_reg;
  logic [5:0] ch_sticky_reg;
  logic fault_reg;
  logic [1:0] hson_reg;

  // ========================================================================
  // bus decode
  wire setup_ph = psel_in & ~penable_in;
  wire access_ph = psel_in & penable_in;
  wire wr_word = access_ph & pwrite_in;
  wire rd_done = access_ph & ~pwrite_in;
  wire hit_ctrl = paddr_in == ADDR_CTRL;
  wire hit_duty0 = paddr_in == ADDR_DUTY0;
  wire hit_duty1 = paddr_in == ADDR_DUTY1;
  wire hit_stat = paddr_in == ADDR_STATUS;
  wire hit_chf = paddr_in == ADDR_CHFAULT;
  wire mapped = hit_ctrl | hit_duty0 | hit_duty1 | hit_stat | hit_chf;
  // serial interface off in sleep, locked in failsafe and until unlocked
  wire locked = (mode_reg == SMSV_SLEEP) | fs_reg | unlock_reg;
  wire wr_ok = wr_word & ~locked & mapped;
  wire wd_bit = pwdata_in[WDOG_BIT];

  // ========================================================================
  // mode conditions
  wire pin_rise = wake_reset_pin_in & ~pin_d_reg;
  wire [1:0] din_rise = direct_in & ~din_d_reg;
  wire wake = wake_reset_pin_in | act_reg[0] | act_reg[1];
  wire wd_expired = wd_run_reg & (wd_cnt_reg == '0);
  wire wd_timeout = wd_expired & ~ctrl_reg[CTRL_WDOFF];
  wire vdd_loss = vdd_seen_reg & ~vdd_ok_in & ctrl_reg[CTRL_VDDLOSS_ARM];
  wire fs_set = wd_timeout | vdd_loss;
  wire [1:0] ch_fault = current_limit_fault_in | thermal_fault_in | hard_short_fault_in;
  wire ov_fault = supply_high_fault_in & ctrl_reg[CTRL_OV_ARM];
  wire fault_now = (|ch_fault) | supply_low_fault_in | ov_fault;
  // leave failsafe on a word with the toggle bit high, whatever the address
  wire fs_exit = fs_reg & wr_word & wd_bit & ~fs_set;
  wire fs_now = (fs_reg | fs_set) & ~fs_exit;

  // mode table; fault outranks failsafe, sleep outranks both
  always_comb begin
    if (!wake) begin
      mode_next = SMSV_SLEEP;
    end else if (fault_now) begin
      mode_next = SMSV_FAULT;
    end else if (fs_now) begin
      mode_next = SMSV_FAILSAFE;
    end else begin
      mode_next = SMSV_NORMAL;
    end
  end

  wire enter_fs = fs_now & ~fs_reg;
  wire enter_norm = (mode_next == SMSV_NORMAL) & (mode_reg != SMSV_NORMAL);
  // sleep, failsafe entry and failsafe exit reset configuration but keep por and parallel
  wire cfg_reset = (mode_next == SMSV_SLEEP) | enter_fs | fs_exit;

  // ========================================================================
  // channel target state
  function automatic logic duty_active(input logic [7:0] duty, input logic [7:0] cnt);
    duty_active = cnt <= duty;  // (n+1)/256 on time, 255 fully on
  endfunction : duty_active

  logic [1:0] hson_next;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire dir_dis = ctrl_reg[CTRL_DIRDIS0 + ch];
      wire pwm_en = ctrl_reg[CTRL_PWMEN0 + ch];
      wire on_bit = duty_reg[ch][DUTY_ON];
      wire pwm_on = duty_active(duty_reg[ch][7:0], pwm_cnt_reg);
      wire spi_tgt = (direct_in[ch] & ~dir_dis) | (on_bit & (pwm_on | ~pwm_en));
      wire direct_only = ~wake_reset_pin_in | fs_reg;
      wire tgt = direct_only ? direct_in[ch] : spi_tgt;
      // per-channel faults gate one channel, supply faults both; fault mode already turns off both
      wire kill = ch_fault[ch] | supply_low_fault_in | ov_fault;
      assign hson_next[ch] = (mode_next == SMSV_NORMAL || mode_next == SMSV_FAILSAFE)
                             & tgt & ~kill;

      // activity flag: reload while high, count down while low
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          act_cnt_reg[ch] <= '0;
          act_reg[ch] <= 1'b0;
        end else if (direct_in[ch] || din_rise[ch]) begin
          act_cnt_reg[ch] <= INW'(IN_TO_CYC);
          act_reg[ch] <= 1'b1;
        end else if (act_cnt_reg[ch] != '0) begin
          act_cnt_reg[ch] <= act_cnt_reg[ch] - 1'b1;
        end else begin
          act_reg[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================================
  // watchdog: started by pin rise with vdd, restarted by each toggle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_run_reg <= 1'b0;
      wd_cnt_reg <= '0;
      wd_last_reg <= 1'b0;
    end else if (pin_rise && vdd_ok_in) begin
      wd_run_reg <= 1'b1;
      wd_cnt_reg <= WDW'(WD_TO_CYC);
    end else if (fs_exit && vdd_ok_in) begin
      // rearm on exit, else a late second word never meets a timeout
      wd_run_reg <= 1'b1;
      wd_cnt_reg <= WDW'(WD_TO_CYC);
      wd_last_reg <= wd_bit;
    end else if (wr_word && wd_run_reg && wd_bit != wd_last_reg) begin
      wd_cnt_reg <= WDW'(WD_TO_CYC);
      wd_last_reg <= wd_bit;
    end else if (wd_expired || mode_reg == SMSV_SLEEP) begin
      wd_run_reg <= mode_reg != SMSV_SLEEP && !wd_timeout;
      wd_cnt_reg <= WDW'(WD_TO_CYC);
    end else if (wd_run_reg) begin
      wd_cnt_reg <= wd_cnt_reg - 1'b1;
    end
  end

  // ========================================================================
  // failsafe flag and the unlock window after leaving it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fs_reg <= 1'b0;
      unlock_reg <= 1'b0;
    end else begin
      fs_reg <= fs_now & (mode_next != SMSV_SLEEP);
      // second word consumes the window; a late one meets a timeout first
      unlock_reg <= fs_exit | (unlock_reg & ~wr_word & ~fs_set);
    end
  end

  // ========================================================================
  // input edge history and supply memory
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_d_reg <= 1'b0;
      din_d_reg <= 2'b00;
      vdd_seen_reg <= 1'b0;
      pwm_cnt_reg <= 8'h00;
    end else begin
      pin_d_reg <= wake_reset_pin_in;
      din_d_reg <= direct_in;
      vdd_seen_reg <= (vdd_seen_reg | vdd_ok_in) & ~fs_set;
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // ========================================================================
  // configuration registers
  always_comb begin
    ctrl_next = ctrl_reg;
    if (cfg_reset) begin
      ctrl_next = (CTRL_RESET & ~CTRL_KEEP_MASK) | (ctrl_reg & CTRL_KEEP_MASK);
    end else if (wr_ok && hit_ctrl) begin
      ctrl_next = pwdata_in[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= CTRL_RESET;
      duty_reg[0] <= DUTY_RESET;
      duty_reg[1] <= DUTY_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      if (cfg_reset) begin
        duty_reg[0] <= DUTY_RESET;
        duty_reg[1] <= DUTY_RESET;
      end else if (wr_ok && hit_duty0) begin
        duty_reg[0] <= pwdata_in[DUTY_W-1:0];
      end else if (wr_ok && hit_duty1) begin
        duty_reg[1] <= pwdata_in[DUTY_W-1:0];
      end
    end
  end

  // ========================================================================
  // sticky fault bits: set wins over a read, read clears only if gone
  wire [1:0] st_src = {ov_fault, supply_low_fault_in};
  wire [5:0] ch_src = {hard_short_fault_in[1], thermal_fault_in[1], current_limit_fault_in[1],
                       hard_short_fault_in[0], thermal_fault_in[0], current_limit_fault_in[0]};
  wire st_rd = rd_done & hit_stat & ~locked;
  wire chf_rd = rd_done & hit_chf & ~locked;
  wire sticky_clr = enter_fs | fs_exit | enter_norm & (mode_reg == SMSV_SLEEP);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_sticky_reg <= 2'b00;
      ch_sticky_reg <= 6'h00;
    end else if (sticky_clr) begin
      st_sticky_reg <= st_src;
      ch_sticky_reg <= ch_src;
    end else begin
      st_sticky_reg <= st_src | (st_sticky_reg & ~{2{st_rd}});
      ch_sticky_reg <= ch_src | (ch_sticky_reg & ~{6{chf_rd}});
    end
  end

  // ========================================================================
  // mode and pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= SMSV_SLEEP;
      fault_reg <= 1'b0;
      hson_reg <= 2'b00;
    end else begin
      mode_reg <= mode_next;
      fault_reg <= fault_now;
      hson_reg <= hson_next;
    end
  end

  assign hson_out = hson_reg;
  assign mode_out = mode_reg;
  assign failsafe_out_n_out = 1'b0;
  assign failsafe_oe_out = fs_reg;
  assign fault_flag_n_out = 1'b0;
  assign fault_oe_out = fault_reg;

  // ========================================================================
  // apb: read data captured in setup, one access cycle, no wait states
  wire [31:0] rd_mux =
    locked ? 32'h0000_0000 :
    hit_ctrl ? 32'(ctrl_reg) :
    hit_duty0 ? 32'(duty_reg[0]) :
    hit_duty1 ? 32'(duty_reg[1]) :
    hit_stat ? 32'({hson_reg, st_sticky_reg, fault_reg, fs_reg, mode_reg}) :
    hit_chf ? 32'(ch_sticky_reg) : 32'h0000_0000;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_out <= rd_mux;
    end
  end

  assign pready_out = access_ph;
  // unmapped or locked access reports an error, a write word still feeds the watchdog
  assign pslverr_out = access_ph & (~mapped | locked);

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sleep_off_a: assert property (mode_reg == SMSV_SLEEP |-> hson_reg == 2'b00)
    else $error("channel on while sleeping");
  fault_off_a: assert property (mode_reg == SMSV_FAULT |-> hson_reg == 2'b00)
    else $error("channel on in fault mode");
  fault_pin_a: assert property (fault_now |=> !fault_flag_n_out && fault_oe_out)
    else $error("fault pin not asserted one cycle after fault");
  fs_entry_a: assert property (wd_timeout && !fault_now && wake |=>
    mode_reg == SMSV_FAILSAFE && failsafe_oe_out)
    else $error("watchdog timeout did not enter failsafe");
  wdoff_a: assert property (wd_expired && ctrl_reg[CTRL_WDOFF] && !vdd_loss && !fs_reg
    |=> !fs_reg)
    else $error("watchdog expiry entered failsafe while off");
  fs_lock_a: assert property (fs_reg && wr_word && !cfg_reset |=> $stable(ctrl_reg))
    else $error("register written in failsafe");
  sticky_hold_a: assert property (ch_sticky_reg[0] && !chf_rd && !sticky_clr
    |=> ch_sticky_reg[0])
    else $error("sticky bit lost without read");
  act_drop_a: assert property (act_reg[0] && !direct_in[0] ##1 !direct_in[0] [*8]
    |-> act_cnt_reg[0] != INW'(IN_TO_CYC))
    else $error("activity counter not running while idle");
  direct_a: assert property (!wake_reset_pin_in && mode_next == SMSV_NORMAL
    && !ch_fault[0] && !supply_low_fault_in && !ov_fault |=> hson_reg[0] == $past(direct_in[0]))
    else $error("channel not following direct input");
  norm_back_a: assert property (fs_exit && !fault_now && wake |=>
    mode_reg == SMSV_NORMAL && !failsafe_oe_out && unlock_reg)
    else $error("failsafe exit did not restore normal");

  // timers, unlock window, sleep defaults and failsafe pin
  act_low_a: assert property (act_reg[0] && act_cnt_reg[0] == '0 && !direct_in[0]
    |=> !act_reg[0])
    else $error("activity flag held after timeout");
  unlock_a: assert property (unlock_reg && wr_word && wake && !fs_set |=>
    !unlock_reg && $stable(ctrl_reg))
    else $error("unlock word changed registers");
  sleep_dflt_a: assert property (mode_reg == SMSV_SLEEP |->
    duty_reg[0] == DUTY_RESET && duty_reg[1] == DUTY_RESET
    && (ctrl_reg & ~CTRL_KEEP_MASK) == (CTRL_RESET & ~CTRL_KEEP_MASK))
    else $error("registers left off default in sleep");
  wd_feed_a: assert property (wr_word && wd_run_reg && wd_bit != wd_last_reg
    && !pin_rise |=> wd_cnt_reg == WDW'(WD_TO_CYC))
    else $error("toggle bit did not reload watchdog");
  fs_pin_a: assert property (fs_set && wake |=> fs_reg && failsafe_oe_out)
    else $error("failsafe pin not pulled low on entry");

  wake_c: cover property (mode_reg == SMSV_SLEEP ##1 mode_reg == SMSV_NORMAL);
  fs_c: cover property (mode_reg == SMSV_NORMAL ##1 mode_reg == SMSV_FAILSAFE);
  fs_back_c: cover property (mode_reg == SMSV_FAILSAFE ##1 mode_reg == SMSV_NORMAL);
  fault_c: cover property (mode_reg == SMSV_FAILSAFE ##1 mode_reg == SMSV_FAULT);
  unlock_c: cover property (unlock_reg ##1 !unlock_reg && mode_reg == SMSV_NORMAL);
endmodule : smsv_supervisor

//--- hw/smsv_pkg.sv
// ==========================================================================
// shared constants of the switch mode supervisor
package smsv_pkg;
  // ========================================================================
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned IN_TIMEOUT_MS = 250;
  localparam int unsigned WDOG_TIMEOUT_MS = 310;
  localparam int unsigned IN_TIMEOUT_CYC =
    32'((64'(IN_TIMEOUT_MS) * 64'(CLK_HZ)) / 64'd1000);
  localparam int unsigned WDOG_TIMEOUT_CYC =
    32'((64'(WDOG_TIMEOUT_MS) * 64'(CLK_HZ)) / 64'd1000);

  // ========================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DUTY0 = 12'h004;
  localparam logic [11:0] ADDR_DUTY1 = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_CHFAULT = 12'h010;

  // ========================================================================
  // global control register fields
  localparam int CTRL_W = 13;
  localparam int CTRL_VDDLOSS_ARM = 0;
  localparam int CTRL_OV_ARM = 1;
  localparam int CTRL_DIRDIS0 = 2;
  localparam int CTRL_WDOFF = 4;
  localparam int CTRL_PARALLEL = 5;
  localparam int CTRL_POR = 6;
  localparam int CTRL_PWMEN0 = 7;
  localparam int CTRL_OFFSHORT_EN = 9;
  localparam int CTRL_OLOFF_EN = 10;
  localparam int CTRL_OLON_EN = 11;
  localparam int CTRL_CLKFAIL_EN = 12;
  localparam logic [12:0] CTRL_RESET = 13'h1042;
  localparam logic [12:0] CTRL_KEEP_MASK = 13'h0060;

  // ========================================================================
  // duty register fields and serial word layout
  localparam int DUTY_W = 9;
  localparam int DUTY_ON = 8;
  localparam logic [8:0] DUTY_RESET = 9'h000;
  localparam int WDOG_BIT = 15;

  // ========================================================================
  // status register fields
  localparam int ST_FS = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_UV = 4;
  localparam int ST_OV = 5;
  localparam int ST_HSON = 6;

  // ========================================================================
  // operating modes, gray coded along sleep-normal-failsafe-fault
  typedef enum logic [1:0] {
    SMSV_SLEEP = 2'b00,
    SMSV_NORMAL = 2'b01,
    SMSV_FAILSAFE = 2'b11,
    SMSV_FAULT = 2'b10
  } smsv_mode_t;
endpackage : smsv_pkg

//--- tb/smsv_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// host pins: wake/reset pin and direct inputs, launched just after the edge
module smsv_host_model (
  input wire logic clk_in,  // oscillator clock
  input wire logic rst_n_in,  // async reset, active low
  input wire logic wake_cmd_in,  // requested wake pin level
  input wire logic [1:0] dir_cmd_in,  // requested direct input levels
  output logic wake_reset_pin_out,  // wake/reset pin
  output logic [1:0] direct_out  // direct channel inputs
);
  // pins held low in reset so the device stays asleep until the host moves
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_reset_pin_out <= 1'b0;
      direct_out <= 2'b00;
    end else begin
      wake_reset_pin_out <= wake_cmd_in;
      direct_out <= dir_cmd_in;
    end
  end
endmodule : smsv_host_model

//--- tb/switch_mode_supervisor_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// bench for the mode supervisor, short timeouts to keep the run brief
module switch_mode_supervisor_bench;
  import smsv_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_wake, fs_n, fs_oe, ft_n, ft_oe;
  logic wake_cmd = 1'b0;
  logic vdd_ok = 1'b1;
  logic [1:0] dir_cmd = 2'b00;
  logic [1:0] pin_dir, hson, mode;
  int pwm_hi = 0;
  logic [7:0] flt = 8'h00;
  logic [31:0] rd;
  logic er;
  logic wd_tog = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_in = ~clk_in;

  smsv_host_model host (.clk_in(clk_in), .rst_n_in(rst_n_in), .wake_cmd_in(wake_cmd),
    .dir_cmd_in(dir_cmd), .wake_reset_pin_out(pin_wake), .direct_out(pin_dir));

  smsv_supervisor #(.IN_TO_CYC(50), .WD_TO_CYC(80)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .wake_reset_pin_in(pin_wake), .direct_in(pin_dir), .vdd_ok_in(vdd_ok),
    .current_limit_fault_in(flt[1:0]), .thermal_fault_in(flt[3:2]),
    .hard_short_fault_in(flt[5:4]), .supply_low_fault_in(flt[6]),
    .supply_high_fault_in(flt[7]), .hson_out(hson), .mode_out(mode),
    .failsafe_out_n_out(fs_n), .failsafe_oe_out(fs_oe), .fault_flag_n_out(ft_n),
    .fault_oe_out(ft_oe));

  // ========================================================================
  // reporting
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // a hang ends the run here instead of stalling forever
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      $display("FAIL %0t timeout", $time);
      err_total = err_total + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task chm(input smsv_mode_t exp, input string what);
    chk({30'h0, mode}, {30'h0, exp}, what);
  endtask : chm

  // sample one unit past the edge so registered outputs have landed
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task done(input string name);
    $display("test %s done", name);
  endtask : done

  // ========================================================================
  // apb master: setup, then access held until pready at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // every write is a serial word; the toggle bit alternates word by word
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, {d[31:16], wd_tog, d[14:0]});
    wd_tog = ~wd_tog;
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdc

  task setin(input logic w, input logic [1:0] d);
    @(posedge clk_in);
    wake_cmd <= w;
    dir_cmd <= d;
  endtask : setin

  // ========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(1);
    chm(SMSV_SLEEP, "default sleep");
    chk({30'h0, fs_oe, ft_oe}, 32'h0, "pins idle");
    chk({30'h0, fs_n, ft_n}, 32'h0, "pin levels");
    chk({30'h0, hson}, 32'h0, "channels off");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk({31'h0, er}, 32'h1, "sleep access");
    done("sleep");
    setin(1'b1, 2'b00);
    cyc(3);
    chm(SMSV_NORMAL, "wake pin");
    rdc(ADDR_CTRL, 32'h0000_1042, "ctrl reset");
    rdc(12'h020, 32'h0, "unmapped read");
    chk({31'h0, er}, 32'h1, "unmapped error");
    wr(ADDR_DUTY0, 32'h0000_01ff);
    cyc(3);
    chk({30'h0, hson}, 32'h1, "on bit");
    done("wake");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      flt <= 8'h01 << i;
      cyc(3);
      chm(SMSV_FAULT, "fault mode");
      chk({31'h0, ft_oe}, 32'h1, "fault pin");
      chk({30'h0, hson}, 32'h0, "fault off");
      @(posedge clk_in);
      flt <= 8'h00;
      cyc(3);
      chk({31'h0, ft_oe}, 32'h0, "fault pin live");
      chm(SMSV_NORMAL, "fault gone");
      wr(ADDR_CTRL, 32'h0000_1042);
    end
    rdc(ADDR_CHFAULT, 32'h0000_003f, "sticky set");
    rdc(ADDR_CHFAULT, 32'h0, "read clears");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h3, "supply sticky");
    done("faults");
    cyc(100);
    chm(SMSV_FAILSAFE, "watchdog expiry");
    chk({31'h0, fs_oe}, 32'h1, "failsafe pin");
    setin(1'b1, 2'b01);
    cyc(3);
    chk({30'h0, hson}, 32'h1, "direct only");
    setin(1'b1, 2'b00);
    wd_tog = 1'b0;
    wr(ADDR_CTRL, 32'h0000_1052);
    chk({31'h0, er}, 32'h1, "failsafe locked");
    wr(ADDR_CTRL, 32'h0000_1052);
    cyc(2);
    chm(SMSV_NORMAL, "failsafe exit");
    chk({31'h0, fs_oe}, 32'h0, "failsafe pin high");
    wr(ADDR_CTRL, 32'h0000_1052);
    chk({31'h0, er}, 32'h1, "unlock word");
    wr(ADDR_CTRL, 32'h0000_1052);
    chk({31'h0, er}, 32'h0, "unlocked");
    rdc(ADDR_CTRL, 32'h0000_1052, "watchdog off");
    rdc(ADDR_DUTY0, 32'h0, "duty reset");
    wr(ADDR_DUTY1, 32'h0000_0100);
    wr(ADDR_CTRL, 32'h0000_1152);
    cyc(2);
    repeat (256) begin
      cyc(1);
      pwm_hi = pwm_hi + int'(hson[1]);
    end
    chk(pwm_hi, 32'd1, "duty zero on once");
    chm(SMSV_NORMAL, "no expiry");
    wr(ADDR_CTRL, 32'h0000_1153);
    @(posedge clk_in);
    vdd_ok <= 1'b0;
    cyc(3);
    chm(SMSV_FAILSAFE, "supply loss");
    done("failsafe");
    setin(1'b0, 2'b00);
    cyc(3);
    chm(SMSV_SLEEP, "pin low idle");
    setin(1'b0, 2'b10);
    @(posedge clk_in);
    setin(1'b0, 2'b00);
    cyc(3);
    chm(SMSV_NORMAL, "direct wake");
    cyc(40);
    chk({31'h0, mode !== SMSV_SLEEP}, 32'h1, "activity held");
    cyc(20);
    chm(SMSV_SLEEP, "activity timeout");
    done("sleep entry");
    final_report();
  end
endmodule : switch_mode_supervisor_bench
